// *** common/nibble_alu_defs.svh ***
// Constants for the nibble datapath: widths and operation codes.
// Assumes inclusion by bare name from every design file except the interface.
`ifndef NIBBLE_ALU_DEFS_SVH
`define NIBBLE_ALU_DEFS_SVH

`define NIB_W         4
`define ADDR_W        8
`define NIB_ZERO      4'h0
`define NIB_ONE       4'h1
`define CARRY_RST     1'b0

// Operation codes on op_code
`define OP_NOP        5'h00
`define OP_ADD        5'h01
`define OP_SUB        5'h02
`define OP_ADN        5'h03
`define OP_AND        5'h04
`define OP_XOR        5'h05
`define OP_OR         5'h06
`define OP_ADD_IMM_WITH_CARRY       5'h07
`define OP_SUB_IMM_WITH_BORROW       5'h08
`define OP_ADD_IMM       5'h09
`define OP_SUB_IMM       5'h0a
`define OP_ADD_IMM_KEEP_FLAG       5'h0b
`define OP_CONJ_IMM       5'h0c
`define OP_XORI       5'h0d
`define OP_ORI        5'h0e
`define OP_STORE      5'h0f
`define OP_LDS        5'h10
`define OP_LOAD       5'h11

`endif

// *** common/nibble_alu_pkg.sv ***
// Types for the nibble datapath.
// Assumes the defs header is on the include path.
`include "nibble_alu_defs.svh"
package nibble_alu_pkg;
	typedef logic [`NIB_W-1:0]  nib_t;
	typedef logic [`ADDR_W-1:0] addr_t;
	typedef enum logic [1:0] {
		FN_ADD,
		FN_AND,
		FN_XOR,
		FN_OR
	} alu_fn_t;
endpackage

// *** common/alu_if.sv ***
// Interface between the datapath sequencer and its arithmetic unit.
// Assumes both ends run on mclk.
`timescale 1ns/10ps
interface alu_if;
	import nibble_alu_pkg::*;
	nib_t    opa;
	nib_t    opb;
	logic    inv_b;
	logic    cin;
	alu_fn_t fn;
	nib_t    res;
	logic    cout;
	modport unit (input opa, opb, inv_b, cin, fn, output res, cout);
	modport user (output opa, opb, inv_b, cin, fn, input res, cout);
endinterface

// *** core/nibble_arith.sv ***
// Combinational 4-bit adder and logic unit.
// Assumes operands are stable within the cycle.
`timescale 1ns/10ps
`include "nibble_alu_defs.svh"
module nibble_arith
	import nibble_alu_pkg::*;
(
	alu_if.unit a
);
	logic [`NIB_W:0] sum;
	nib_t            b_eff;

	always_comb begin
		b_eff = a.inv_b ? ~a.opb : a.opb;
		sum   = {1'b0, a.opa} + {1'b0, b_eff} + {`NIB_W'(0), a.cin};
	end

	// Results cut to four bits; fifth bit only as carry
	always_comb begin
		a.cout = sum[`NIB_W]; // RL20 RL21
		unique case (a.fn)
			FN_ADD: a.res = sum[`NIB_W-1:0];
			FN_AND: a.res = a.opa & a.opb;
			FN_XOR: a.res = a.opa ^ a.opb;
			FN_OR:  a.res = a.opa | a.opb;
		endcase
	end
endmodule

// *** core/op_decode.sv ***
// Decodes an operation code into unit controls and datapath moves.
// Assumes codes from the defs header.
`timescale 1ns/10ps
`include "nibble_alu_defs.svh"
module op_decode
	import nibble_alu_pkg::*;
(
	input  wire logic [4:0] op_code,
	output alu_fn_t         fn,
	output logic            inv_b,
	output logic            cin_one,
	output logic            cin_cf,
	output logic            use_imm,
	output logic            upd_cf,
	output logic            mem_src,
	output logic            known
);
	always_comb begin
		fn = FN_ADD;
		inv_b = 1'b0;
		cin_one = 1'b0;
		cin_cf = 1'b0;
		use_imm = 1'b0;
		upd_cf = 1'b0;
		mem_src = 1'b1;
		known = 1'b1;
		unique case (op_code)
			`OP_ADD: upd_cf = 1'b1; // RL6
			`OP_SUB: begin
				inv_b = 1'b1; // RL1
				cin_one = 1'b1;
				upd_cf = 1'b1;
			end
			`OP_ADN: ; // RL5
			`OP_AND: fn = FN_AND; // RL7
			`OP_XOR: fn = FN_XOR; // RL8
			`OP_OR:  fn = FN_OR; // RL9
			`OP_ADD_IMM_WITH_CARRY: begin
				mem_src = 1'b0; // RL11
				use_imm = 1'b1;
				cin_cf = 1'b1;
				upd_cf = 1'b1;
			end
			`OP_SUB_IMM_WITH_BORROW: begin
				mem_src = 1'b0; // RL12
				use_imm = 1'b1;
				inv_b = 1'b1;
				cin_cf = 1'b1;
				upd_cf = 1'b1;
			end
			`OP_ADD_IMM: begin
				mem_src = 1'b0; // RL14
				use_imm = 1'b1;
				upd_cf = 1'b1;
			end
			`OP_SUB_IMM: begin
				mem_src = 1'b0; // RL13
				use_imm = 1'b1;
				inv_b = 1'b1;
				cin_one = 1'b1;
				upd_cf = 1'b1;
			end
			`OP_ADD_IMM_KEEP_FLAG: begin
				mem_src = 1'b0; // RL5
				use_imm = 1'b1;
			end
			`OP_CONJ_IMM: begin
				mem_src = 1'b0; // RL15
				use_imm = 1'b1;
				fn = FN_AND;
			end
			`OP_XORI: begin
				mem_src = 1'b0;
				use_imm = 1'b1;
				fn = FN_XOR;
			end
			`OP_ORI: begin
				mem_src = 1'b0;
				use_imm = 1'b1;
				fn = FN_OR;
			end
			`OP_STORE, `OP_LDS, `OP_LOAD: ;
			default: known = 1'b0;
		endcase
	end
endmodule

// *** core/nibble_alu_load_store.sv ***
// Nibble arithmetic, logic and load/store datapath of a small core.
// Assumes a decoder issuing one op per exec pulse and a memory port
// that returns read data combinationally for the address it is given.
//
// Function
// RL1 - Memory subtract: mem plus not result plus one
// RL2 - Subtract write-back also writes memory operand
// RL3 - Indirect form addresses memory by index pointer
// RL4 - Write-back add updates result, memory, carry
// RL5 - No-flag adds keep carry unchanged
// RL6 - Memory add gives 4-bit sum to result
// RL7 - AND memory with result, bitwise
// RL8 - XOR memory with result, bitwise
// RL9 - OR memory with result, bitwise
// RL10 - Immediate is any 4-bit value
// RL11 - Immediate add with carry updates carry
// RL12 - Immediate subtract with borrow uses carry
// RL13 - Immediate subtract: reg plus not imm plus one
// RL14 - Immediate add without carry-in updates carry
// RL15 - Immediate logic ops to result register
// RL16 - Immediate write-back also writes working register
// RL17 - Store writes result to memory, keeps result
// RL18 - Load immediate writes result and memory
// RL19 - Load copies memory into result only
// RL20 - Subtract carry set means no borrow
// RL21 - Results four bits, fifth bit only carry
`timescale 1ns/10ps
`include "nibble_alu_defs.svh"
module nibble_alu_load_store
	import nibble_alu_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              resetn,
	input  wire logic              exec,
	input  wire logic [4:0]        op_code,
	input  wire logic              write_back,
	input  wire logic              indirect,
	input  wire logic [`ADDR_W-1:0] direct_addr,
	input  wire logic [`ADDR_W-1:0] index_pointer,
	input  wire logic [`NIB_W-1:0] imm_value,
	input  wire logic [`NIB_W-1:0] work_reg_operand,
	input  wire logic [`NIB_W-1:0] mem_rdata,
	output logic [`ADDR_W-1:0]     mem_addr,
	output logic                   mem_we,
	output logic [`NIB_W-1:0]      mem_wdata,
	output logic                   work_we,
	output logic [`NIB_W-1:0]      work_wdata,
	output logic [`NIB_W-1:0]      result_nibble_reg,
	output logic                   carry_bit,
	output logic                   op_error
);
	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	alu_fn_t fn;
	logic    inv_b;
	logic    cin_one;
	logic    cin_cf;
	logic    use_imm;
	logic    upd_cf;
	logic    mem_src;
	logic    known;

	op_decode u_dec (
		.op_code (op_code),
		.fn      (fn),
		.inv_b   (inv_b),
		.cin_one (cin_one),
		.cin_cf  (cin_cf),
		.use_imm (use_imm),
		.upd_cf  (upd_cf),
		.mem_src (mem_src),
		.known   (known)
	);

	function automatic logic is_alu(input logic [4:0] op);
		is_alu = (op != `OP_NOP) && (op != `OP_STORE) &&
			(op != `OP_LDS) && (op != `OP_LOAD);
	endfunction

	// ------------------------------------------------------------
	// Arithmetic unit
	// ------------------------------------------------------------
	alu_if ai ();
	nibble_arith u_arith (
		.a (ai)
	);

	// Memory forms take the memory nibble as A and result as B so the
	// subtract reads mem + ~result + 1
	always_comb begin
		ai.opa   = mem_src ? mem_rdata : work_reg_operand;
		ai.opb   = use_imm ? imm_value : result_nibble_reg; // RL10
		ai.inv_b = inv_b;
		ai.fn    = fn;
		ai.cin   = cin_one | (cin_cf & carry_bit); // RL12
	end

	// ------------------------------------------------------------
	// Memory and working register port
	// ------------------------------------------------------------
	logic go;
	logic alu_op;
	assign go     = exec & known;
	assign alu_op = is_alu(op_code);

	// Load immediate only takes a direct address
	always_comb begin
		if (indirect && op_code != `OP_LDS)
			mem_addr = index_pointer; // RL3
		else
			mem_addr = direct_addr;
	end

	always_comb begin
		mem_we = 1'b0;
		mem_wdata = ai.res;
		if (go) begin
			if (alu_op && mem_src && write_back)
				mem_we = 1'b1; // RL2 RL4
			if (op_code == `OP_STORE) begin
				mem_we = 1'b1; // RL17
				mem_wdata = result_nibble_reg;
			end
			if (op_code == `OP_LDS) begin
				mem_we = 1'b1; // RL18
				mem_wdata = imm_value;
			end
		end
	end

	assign work_we    = go & alu_op & ~mem_src & write_back; // RL16
	assign work_wdata = ai.res;

	// ------------------------------------------------------------
	// Result register and carry
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			result_nibble_reg <= `NIB_ZERO;
		end else if (go) begin
			if (alu_op)
				result_nibble_reg <= ai.res; // RL6 RL21
			else if (op_code == `OP_LDS)
				result_nibble_reg <= imm_value; // RL18
			else if (op_code == `OP_LOAD)
				result_nibble_reg <= mem_rdata; // RL19
		end
	end

	// Carry moves only for flag-updating arithmetic forms
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			carry_bit <= `CARRY_RST;
		end else if (go && upd_cf) begin
			carry_bit <= ai.cout; // RL20 RL5
		end
	end

	// Unknown codes are ignored and flagged for one cycle
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			op_error <= 1'b0;
		else
			op_error <= exec & ~known;
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	logic [`NIB_W:0] ref_sub;
	assign ref_sub = {1'b0, mem_rdata} + {1'b0, ~result_nibble_reg} +
		{`NIB_W'(0), 1'b1};

	sequence s_sub_mem;
		exec && op_code == `OP_SUB && mem_src;
	endsequence

	chk_sub_result: assert property (@(posedge mclk) disable iff (!resetn) // RL1
		s_sub_mem |=> result_nibble_reg == $past(ref_sub[`NIB_W-1:0])
			&& carry_bit == $past(ref_sub[`NIB_W]))
		else $error("subtract result or carry wrong");

	chk_sub_wb: assert property (@(posedge mclk) disable iff (!resetn) // RL2
		exec && op_code == `OP_SUB && write_back |->
			mem_we && mem_wdata == ref_sub[`NIB_W-1:0])
		else $error("subtract write-back missing");

	chk_indirect_addr: assert property (@(posedge mclk) disable iff (!resetn) // RL3
		indirect && op_code != `OP_LDS |-> mem_addr == index_pointer)
		else $error("indirect address not index pointer");

	chk_add_wb: assert property (@(posedge mclk) disable iff (!resetn) // RL4
		exec && op_code == `OP_ADD && write_back |->
			mem_we && mem_wdata == mem_rdata + result_nibble_reg)
		else $error("add write-back wrong");

	chk_adn_keep: assert property (@(posedge mclk) disable iff (!resetn) // RL5
		exec && (op_code == `OP_ADN || op_code == `OP_ADD_IMM_KEEP_FLAG) |=>
			$stable(carry_bit))
		else $error("no-flag add changed carry");

	chk_and_mem: assert property (@(posedge mclk) disable iff (!resetn) // RL7
		exec && op_code == `OP_AND |=>
			result_nibble_reg == ($past(mem_rdata) &
			$past(result_nibble_reg)))
		else $error("and result wrong");

	chk_add_imm_with_carry_sum: assert property (@(posedge mclk) disable iff (!resetn) // RL11
		exec && op_code == `OP_ADD_IMM_WITH_CARRY |=>
			{carry_bit, result_nibble_reg} ==
			{1'b0, $past(work_reg_operand)} + {1'b0, $past(imm_value)}
			+ {`NIB_W'(0), $past(carry_bit)})
		else $error("add with carry wrong");

	chk_imm_wb: assert property (@(posedge mclk) disable iff (!resetn) // RL16
		exec && known && !mem_src && write_back && is_alu(op_code) |->
			work_we && work_wdata == ai.res)
		else $error("immediate write-back missing");

	chk_store_keep: assert property (@(posedge mclk) disable iff (!resetn) // RL17
		exec && op_code == `OP_STORE |-> mem_we &&
			mem_wdata == result_nibble_reg ##1 $stable(result_nibble_reg))
		else $error("store wrong");

	chk_load_only: assert property (@(posedge mclk) disable iff (!resetn) // RL19
		exec && op_code == `OP_LOAD |-> !mem_we ##1
			result_nibble_reg == $past(mem_rdata))
		else $error("load wrong");
endmodule

// *** testbench/data_mem_model.sv ***
// Data memory on the far side of the datapath's memory port.
// Assumes one write strobe per cycle, sampled on the rising mclk.
`timescale 1ns/10ps
`include "nibble_alu_defs.svh"
module data_mem_model
	import nibble_alu_pkg::*;
(
	input  wire logic  mclk,
	input  wire addr_t addr,
	input  wire logic  we,
	input  wire nib_t  wdata,
	output nib_t       rdata
);
	nib_t mem [256];

	initial begin
		foreach (mem[i]) mem[i] = 4'h0;
	end

	// Same-cycle read, as the datapath takes its operand combinationally
	assign rdata = mem[addr];

	always @(posedge mclk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
	end
endmodule

// *** testbench/tb_top.sv ***
// Self-checking bench for the nibble datapath.
// Assumes the memory model answers reads in the same cycle.
`timescale 1ns/10ps
`include "nibble_alu_defs.svh"
module tb_top;
	import nibble_alu_pkg::*;
	logic       mclk, resetn, exec, write_back, indirect;
	logic [4:0] op_code;
	addr_t      direct_addr, index_pointer, mem_addr;
	nib_t       imm_value, work_reg_operand, mem_rdata, mem_wdata;
	nib_t       work_wdata, result_nibble_reg;
	logic       mem_we, work_we, carry_bit, op_error;
	int         err_count = 0;
	int         checks_done = 0;
	nib_t       acc = 4'h0;
	logic       cf = 1'b0;
	nib_t       exp_mem [256];

	nibble_alu_load_store u_nibble_alu_load_store (.mclk(mclk),
		.resetn(resetn), .exec(exec), .op_code(op_code),
		.write_back(write_back), .indirect(indirect),
		.direct_addr(direct_addr), .index_pointer(index_pointer),
		.imm_value(imm_value), .work_reg_operand(work_reg_operand),
		.mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_we(mem_we),
		.mem_wdata(mem_wdata), .work_we(work_we), .work_wdata(work_wdata),
		.result_nibble_reg(result_nibble_reg), .carry_bit(carry_bit),
		.op_error(op_error));
	data_mem_model u_data_mem_model (.mclk(mclk), .addr(mem_addr),
		.we(mem_we), .wdata(mem_wdata), .rdata(mem_rdata));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic cmp_nib(input nib_t got, input nib_t exp, input string w);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t %s got %h exp %h", $time, w, got, exp);
		end
	endtask

	task automatic cmp_bit(input logic got, input logic exp, input string w);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t %s got %b exp %b", $time, w, got, exp);
		end
	endtask

	// One op, entered just after an edge; back to back calls share exec
	task automatic do_op(input logic [4:0] op, input logic wb,
		input logic ind, input addr_t ad, input nib_t imm, input nib_t wr);
		addr_t      ea;
		nib_t       a, nb, ni;
		logic [4:0] s;
		logic       mw, ww, uc, imo;
		ea = (ind && op != `OP_LDS) ? index_pointer : ad;
		a = exp_mem[ea];
		nb = ~acc;
		ni = ~imm;
		imo = op inside {[`OP_ADD_IMM_WITH_CARRY:`OP_ORI]};
		uc = op inside {`OP_ADD, `OP_SUB, `OP_ADD_IMM_WITH_CARRY, `OP_SUB_IMM_WITH_BORROW, `OP_ADD_IMM,
			`OP_SUB_IMM};
		mw = (wb && op inside {[`OP_ADD:`OP_OR]}) ||
			op inside {`OP_STORE, `OP_LDS};
		ww = wb && imo;
		case (op)
			`OP_ADD, `OP_ADN: s = a + acc;
			`OP_SUB: s = a + nb + 5'h01;
			`OP_AND: s = {1'b0, a & acc};
			`OP_XOR: s = {1'b0, a ^ acc};
			`OP_OR: s = {1'b0, a | acc};
			`OP_ADD_IMM_WITH_CARRY: s = wr + imm + cf;
			`OP_SUB_IMM_WITH_BORROW: s = wr + ni + cf;
			`OP_ADD_IMM, `OP_ADD_IMM_KEEP_FLAG: s = wr + imm;
			`OP_SUB_IMM: s = wr + ni + 5'h01;
			`OP_CONJ_IMM: s = {1'b0, wr & imm};
			`OP_XORI: s = {1'b0, wr ^ imm};
			`OP_ORI: s = {1'b0, wr | imm};
			`OP_STORE: s = {1'b0, acc};
			`OP_LDS: s = {1'b0, imm};
			default: s = {1'b0, a};
		endcase
		exec = 1'b1;
		op_code = op;
		write_back = wb;
		indirect = ind;
		direct_addr = ad;
		imm_value = imm;
		work_reg_operand = wr;
		#7;
		cmp_bit(mem_we, mw, "mem_we");
		cmp_bit(work_we, ww, "work_we");
		if (!imo) cmp_bit(mem_addr === ea, 1'b1, "mem_addr");
		if (mw) cmp_nib(mem_wdata, s[3:0], "mem_wdata");
		if (ww) cmp_nib(work_wdata, s[3:0], "work_wdata");
		@(posedge mclk);
		#1;
		if (mw) exp_mem[ea] = s[3:0];
		if (op != `OP_STORE) acc = s[3:0];
		if (uc) cf = s[4];
		cmp_nib(result_nibble_reg, acc, "result");
		cmp_bit(carry_bit, cf, "carry");
		cmp_bit(op_error, 1'b0, "op_error");
	endtask

	task automatic end_test(input string name);
		exec = 1'b0;
		@(posedge mclk);
		#1;
		$display("test %s done", name);
	endtask

	task automatic t_moves();
		index_pointer = 8'h20;
		do_op(`OP_LDS, 1'b0, 1'b1, 8'h10, 4'hf, 4'h0);
		do_op(`OP_LDS, 1'b1, 1'b0, 8'h11, 4'h0, 4'h0);
		do_op(`OP_LOAD, 1'b0, 1'b0, 8'h10, 4'h0, 4'h0);
		do_op(`OP_STORE, 1'b1, 1'b1, 8'h00, 4'h0, 4'h0);
		do_op(`OP_LOAD, 1'b0, 1'b0, 8'h11, 4'h0, 4'h0);
		do_op(`OP_LOAD, 1'b0, 1'b1, 8'h11, 4'h0, 4'h0);
		end_test("moves");
	endtask

	// Borrow, carry-out and carry-keeping cases in one chain
	task automatic t_mem_arith();
		index_pointer = 8'h13;
		do_op(`OP_LDS, 1'b0, 1'b0, 8'h13, 4'h5, 4'h0);
		do_op(`OP_LDS, 1'b0, 1'b0, 8'h12, 4'h3, 4'h0);
		do_op(`OP_SUB, 1'b1, 1'b0, 8'h13, 4'h0, 4'h0);
		do_op(`OP_LDS, 1'b0, 1'b0, 8'h15, 4'h9, 4'h0);
		do_op(`OP_SUB, 1'b0, 1'b0, 8'h12, 4'h0, 4'h0);
		do_op(`OP_ADN, 1'b0, 1'b0, 8'h10, 4'h0, 4'h0);
		do_op(`OP_ADD, 1'b1, 1'b0, 8'h15, 4'h0, 4'h0);
		do_op(`OP_ADN, 1'b1, 1'b1, 8'h00, 4'h0, 4'h0);
		do_op(`OP_ADD, 1'b0, 1'b1, 8'h00, 4'h0, 4'h0);
		do_op(`OP_SUB, 1'b1, 1'b1, 8'h00, 4'h0, 4'h0);
		end_test("mem_arith");
	endtask

	task automatic t_logic_mem();
		index_pointer = 8'h40;
		do_op(`OP_LDS, 1'b0, 1'b0, 8'h40, 4'hc, 4'h0);
		do_op(`OP_LDS, 1'b0, 1'b0, 8'h41, 4'ha, 4'h0);
		do_op(`OP_AND, 1'b1, 1'b1, 8'h41, 4'h0, 4'h0);
		do_op(`OP_XOR, 1'b0, 1'b0, 8'h41, 4'h0, 4'h0);
		do_op(`OP_OR, 1'b1, 1'b1, 8'h41, 4'h0, 4'h0);
		do_op(`OP_XOR, 1'b1, 1'b0, 8'h41, 4'h0, 4'h0);
		do_op(`OP_AND, 1'b0, 1'b0, 8'h40, 4'h0, 4'h0);
		do_op(`OP_OR, 1'b0, 1'b0, 8'h41, 4'h0, 4'h0);
		end_test("logic_mem");
	endtask

	// Every immediate op over every immediate, write-back on odd values
	task automatic t_imm();
		for (int op = `OP_ADD_IMM_WITH_CARRY; op <= `OP_ORI; op++) begin
			for (int i = 0; i < 16; i++) begin
				do_op(5'(op), i[0], 1'b0, 8'h00, 4'(i), 4'(i * 7 + op));
			end
		end
		end_test("imm");
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		resetn = 1'b0;
		exec = 1'b0;
		op_code = `OP_NOP;
		write_back = 1'b0;
		indirect = 1'b0;
		direct_addr = 8'h00;
		index_pointer = 8'h00;
		imm_value = 4'h0;
		work_reg_operand = 4'h0;
		foreach (exp_mem[i]) exp_mem[i] = 4'h0;
		repeat (8) @(posedge mclk);
		#1;
		resetn = 1'b1;
		t_moves();
		t_mem_arith();
		t_logic_mem();
		t_imm();
		wrap_up();
	end

	// About 160 op cycles are expected; over twelve times that is a hang
	initial begin
		#20000;
		err_count++;
		$display("BAD %0t watchdog expired", $time);
		wrap_up();
	end
endmodule
